// *** sim/smc_core_props.sv ***
// Port checks for the maintenance command interpreter.
// Assumes the shortened timing parameters handed on by the bind.
`timescale 1ns/10ps
module smc_core_props
import smc_pkg::*;
#(
    parameter int CYC_PER_MS = MS_CYCLES,
    parameter int SAVE_MS = T_SAVE_MS,
    parameter int SERIAL_MS = T_SERIAL_MS,
    parameter int SELF_TEST_MS = T_SELF_TEST_MS,
    parameter int FACTORY_MS = T_FACTORY_MS
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic cmd_valid,
    input wire logic [15:0] cmd_code,
    input wire logic rd_req,
    input wire logic busy,
    input wire logic cmd_nack,
    input wire logic cmd_done,
    input wire logic tx_valid,
    input wire logic tx_nack,
    input wire logic cfg_load,
    input wire logic [15:0] load_temp_offset,
    input wire logic [15:0] load_altitude,
    input wire logic load_auto_baseline_correction
);
    localparam int SV_LO = SAVE_MS * CYC_PER_MS + 1;
    localparam int SV_HI = SV_LO + 1;
    localparam int SN_LO = SERIAL_MS * CYC_PER_MS + 1;
    localparam int SN_HI = SN_LO + 1;
    localparam int ST_LO = SELF_TEST_MS * CYC_PER_MS + 1;
    localparam int ST_HI = ST_LO + 1;
    localparam int FR_LO = FACTORY_MS * CYC_PER_MS + 1;
    localparam int FR_HI = FR_LO + 1;
    logic take;
    logic known;
    assign take = cmd_valid && !busy;
    assign known = cmd_code inside {CMD_SAVE_CFG, CMD_SERIAL, CMD_SELF_TEST,
        CMD_FACTORY_RST};
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////
    unknown_refused_a: assert property (take && !known |=> cmd_nack && !busy)
        else $error("unknown code not refused");
    save_time_a: assert property (take && cmd_code == CMD_SAVE_CFG
        |-> ##[SV_LO:SV_HI] cmd_done) else $error("save done off time");
    serial_time_a: assert property (take && cmd_code == CMD_SERIAL
        |-> ##[SN_LO:SN_HI] cmd_done) else $error("serial done off time");
    test_time_a: assert property (take && cmd_code == CMD_SELF_TEST
        |-> ##[ST_LO:ST_HI] cmd_done) else $error("self-test done off time");
    factory_time_a: assert property (take && cmd_code == CMD_FACTORY_RST
        |-> ##[FR_LO:FR_HI] cmd_done) else $error("factory done off time");
    busy_end_a: assert property ($fell(busy) |-> cmd_done)
        else $error("busy fell without done");
    read_answer_a: assert property (rd_req |=> tx_valid != tx_nack)
        else $error("read request not answered once");
    read_busy_a: assert property (rd_req && busy |=> tx_nack)
        else $error("read while busy not refused");
    load_default_a: assert property (cfg_load |-> load_temp_offset ==
        DEF_TEMP_OFFSET && load_altitude == DEF_ALTITUDE &&
        load_auto_baseline_correction == DEF_AUTO_BASE)
        else $error("factory load not defaults");
    serial_c: cover property (take && cmd_code == CMD_SERIAL);
    load_c: cover property (cfg_load);
    nack_c: cover property (cmd_nack);
endmodule
bind smc_core smc_core_props #(.CYC_PER_MS(CYC_PER_MS), .SAVE_MS(SAVE_MS),
    .SERIAL_MS(SERIAL_MS), .SELF_TEST_MS(SELF_TEST_MS),
    .FACTORY_MS(FACTORY_MS)) u_props (.sys_clk(sys_clk), .arst_n(arst_n),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .rd_req(rd_req),
    .busy(busy), .cmd_nack(cmd_nack), .cmd_done(cmd_done),
    .tx_valid(tx_valid), .tx_nack(tx_nack), .cfg_load(cfg_load),
    .load_temp_offset(load_temp_offset), .load_altitude(load_altitude),
    .load_auto_baseline_correction(load_auto_baseline_correction));

// *** sim/smc_core_tb.sv ***
// Self-checking bench for the maintenance command interpreter.
// Assumes shortened millisecond counts; the host model drives commands.
`timescale 1ns/10ps
module smc_core_tb;
import smc_pkg::*;
    logic sys_clk, arst_n, cmd_valid, rd_req, hist_update, cfg_auto;
    logic busy, cmd_nack, cmd_done, tx_valid, tx_nack, cfg_load, load_auto;
    logic [15:0] cmd_code, cfg_temp, cfg_alt, hist_frc, hist_abc, st_status;
    logic [15:0] load_temp, load_alt;
    logic [7:0] tx_data;
    int mismatches, tests_run, cycles, loads;
    smc_core #(.CYC_PER_MS(4), .SAVE_MS(3), .SERIAL_MS(1), .SELF_TEST_MS(5),
        .FACTORY_MS(12)) u_dut (.sys_clk(sys_clk), .arst_n(arst_n),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .rd_req(rd_req),
        .cfg_temp_offset(cfg_temp), .cfg_altitude(cfg_alt),
        .cfg_auto_baseline_correction(cfg_auto), .hist_update(hist_update),
        .hist_forced_recalibration(hist_frc),
        .hist_auto_baseline_correction(hist_abc),
        .self_test_status(st_status), .busy(busy), .cmd_nack(cmd_nack),
        .cmd_done(cmd_done), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_nack(tx_nack), .cfg_load(cfg_load), .load_temp_offset(load_temp),
        .load_altitude(load_alt), .load_auto_baseline_correction(load_auto));
    smc_host_model u_host (.sys_clk(sys_clk), .cmd_done(cmd_done),
        .tx_data(tx_data), .tx_nack(tx_nack), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .rd_req(rd_req));
    ////////////////////////////////////////
    task automatic chk(input string name, input logic [47:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            c = (c[7] ^ w[i]) ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
        end
        return c;
    endfunction
    task automatic read_word(output logic [15:0] w);
        logic [7:0] b0, b1, b2;
        logic n0, n1, n2;
        u_host.read_byte(b0, n0);
        u_host.read_byte(b1, n1);
        u_host.read_byte(b2, n2);
        w = {b0, b1};
        chk("word nack", 48'h0, {n0, n1, n2});
        chk("word crc", crc8(w), b2);
    endtask
    // The probe reads while busy, which must be refused.
    task automatic run_cmd(input logic [15:0] code, input logic probe);
        logic seen, n;
        logic [7:0] b;
        u_host.send_cmd(code);
        if (probe) begin
            u_host.read_byte(b, n);
            chk("busy read nack", 48'h1, n);
        end
        u_host.wait_done(80, seen);
        chk("cmd_done", 48'h1, seen);
    endtask
    task automatic t_serial;
        logic [15:0] w0, w1, w2;
        logic [7:0] b;
        logic n;
        run_cmd(CMD_SERIAL, 1'b0);
        read_word(w0);
        read_word(w1);
        read_word(w2);
        chk("serial", SERIAL_DEFAULT, {w0, w1, w2});
        u_host.read_byte(b, n);
        chk("tenth byte nack", 48'h1, n);
    endtask
    task automatic t_self_test(input logic [15:0] status);
        logic [15:0] w;
        st_status <= status;
        run_cmd(CMD_SELF_TEST, 1'b1);
        read_word(w);
        chk("self-test status", status, w);
    endtask
    task automatic t_save_factory;
        logic [7:0] b;
        logic n;
        @(posedge sys_clk);
        hist_update <= 1'b1;
        hist_frc <= 16'h1234;
        hist_abc <= 16'h0077;
        @(posedge sys_clk);
        hist_update <= 1'b0;
        repeat (4) @(posedge sys_clk);
        cfg_temp <= 16'h0a5c;
        cfg_alt <= 16'h01f4;
        cfg_auto <= 1'b0;
        run_cmd(CMD_SAVE_CFG, 1'b0);
        u_host.read_byte(b, n);
        chk("save no response", 48'h1, n);
        chk("saved config", {16'h0a5c, 16'h01f4, 16'h0000},
            {u_dut.u_store.mem[NV_TEMP_OFFSET],
            u_dut.u_store.mem[NV_ALTITUDE],
            u_dut.u_store.mem[NV_AUTO_BASE]});
        // A mid-run reset must leave the stored words alone.
        @(posedge sys_clk);
        arst_n <= 1'b0;
        @(posedge sys_clk);
        arst_n <= 1'b1;
        #1;
        chk("reset outputs", 48'h0, {busy, cmd_nack, cmd_done, tx_valid,
            tx_nack, cfg_load});
        chk("history", {16'h1234, 16'h0077},
            {u_dut.u_store.mem[NV_FORCED_HIST],
            u_dut.u_store.mem[NV_AUTO_HIST]});
        run_cmd(CMD_FACTORY_RST, 1'b0);
        chk("load pulses", 48'h1, loads);
        chk("cleared config", {DEF_TEMP_OFFSET, DEF_ALTITUDE, 15'h0000,
            DEF_AUTO_BASE}, {u_dut.u_store.mem[NV_TEMP_OFFSET],
            u_dut.u_store.mem[NV_ALTITUDE],
            u_dut.u_store.mem[NV_AUTO_BASE]});
        chk("cleared history", 48'h0,
            {u_dut.u_store.mem[NV_FORCED_HIST],
            u_dut.u_store.mem[NV_AUTO_HIST]});
        u_host.send_cmd(16'h3646);
        #1;
        chk("unknown nack", 48'h1, cmd_nack);
    endtask
    always @(posedge sys_clk) begin
        if (cfg_load === 1'b1) begin
            loads++;
            chk("defaults", {DEF_TEMP_OFFSET, DEF_ALTITUDE, DEF_AUTO_BASE},
                {load_temp, load_alt, load_auto});
        end
    end
    task automatic final_report;
        $display("Comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            final_report();
        end
    end
    initial begin
        arst_n = 1'b0;
        hist_update = 1'b0;
        cfg_auto = 1'b1;
        cfg_temp = 16'h0000;
        cfg_alt = 16'h0000;
        hist_frc = 16'h0000;
        hist_abc = 16'h0042;
        st_status = 16'h0000;
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        chk("crc reference", 48'h81, crc8(16'h0000));
        chk("crc reference", 48'ha2, crc8(16'h8000));
        t_serial();
        t_self_test(16'h0000);
        t_self_test(16'hbeef);
        t_save_factory();
        final_report();
    end
endmodule

// *** sim/smc_host_model.sv ***
// Bus controller model issuing commands and fetching response bytes.
// Assumes the interpreter's one-cycle response pulses.
`timescale 1ns/10ps
module smc_host_model (
    input wire logic sys_clk,
    input wire logic cmd_done,
    input wire logic [7:0] tx_data,
    input wire logic tx_nack,
    output logic cmd_valid,
    output logic [15:0] cmd_code,
    output logic rd_req
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 16'h0000;
        rd_req = 1'b0;
    end
    // A released code shows its inverse so a stale value cannot match.
    task automatic send_cmd(input logic [15:0] code);
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_code <= code;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        cmd_code <= ~code;
    endtask
    task automatic wait_done(input int limit, output logic seen);
        seen = 1'b0;
        for (int n = 0; n < limit && !seen; n++) begin
            @(posedge sys_clk);
            #1;
            seen = (cmd_done === 1'b1);
        end
    endtask
    task automatic read_byte(output logic [7:0] data, output logic nack);
        @(posedge sys_clk);
        rd_req <= 1'b1;
        @(posedge sys_clk);
        rd_req <= 1'b0;
        #1;
        data = tx_data;
        nack = tx_nack;
    endtask
endmodule

// *** src/smc_core.sv ***
// Maintenance command interpreter: save, serial number, self-test, reset.
// Assumes a byte-level bus front end on the same clock delivering whole
// 16-bit command codes and asking for response bytes one at a time.
`timescale 1ns/10ps

//
// Summary of operation
// R1: The save command copies the live configuration into the store and ends within 800 ms.
// R2: Live configuration is held outside in volatile logic and is lost at power loss.
// R3: The controller should save only when the configuration really changed.
// R4: Calibration history is written to the store on its own whenever it changes.
// R5: The serial command yields nine bytes after 1 ms, three words each with a checksum.
// R6: The controller joins the three serial words into 48 bits, first word highest.
// R7: The self-test command answers after 10000 ms with one status word and checksum.
// R8: The self-test status word is zero on success and nonzero on a fault.
// R9: The factory reset restores default configuration and clears both histories in 1200 ms.
// R10: Each checksum is a CRC-8 with polynomial 0x31 and start value 0xff over its word.
// R11: The controller sends each command code high byte first in one write.
module smc_core
import smc_pkg::*;
#(
    parameter int CYC_PER_MS = MS_CYCLES,
    parameter int SAVE_MS = T_SAVE_MS,
    parameter int SERIAL_MS = T_SERIAL_MS,
    parameter int SELF_TEST_MS = T_SELF_TEST_MS,
    parameter int FACTORY_MS = T_FACTORY_MS,
    parameter logic [47:0] SERIAL_NUM = SERIAL_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic cmd_valid,
    input wire logic [15:0] cmd_code,
    input wire logic rd_req,
    input wire logic [15:0] cfg_temp_offset,
    input wire logic [15:0] cfg_altitude,
    input wire logic cfg_auto_baseline_correction,
    input wire logic hist_update,
    input wire logic [15:0] hist_forced_recalibration,
    input wire logic [15:0] hist_auto_baseline_correction,
    input wire logic [15:0] self_test_status,
    output logic busy,
    output logic cmd_nack,
    output logic cmd_done,
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic tx_nack,
    output logic cfg_load,
    output logic [15:0] load_temp_offset,
    output logic [15:0] load_altitude,
    output logic load_auto_baseline_correction
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        smc_state_t state;
        smc_op_t op;
        logic [2:0] idx;
        logic [15:0] tick;
        logic [13:0] ms_left;
        logic [71:0] rsp_buf;
        logic [3:0] rsp_left;
        logic hist_pend;
        logic busy;
        logic cmd_nack;
        logic cmd_done;
        logic [7:0] tx_data;
        logic tx_valid;
        logic tx_nack;
        logic cfg_load;
        logic [15:0] ld_toff;
        logic [15:0] ld_alt;
        logic ld_abc;
    } smc_regs_t;

    smc_regs_t r_r;
    smc_regs_t r_nxt;
    logic nv_we;
    logic [2:0] nv_waddr;
    logic [15:0] nv_wdata;
    logic [2:0] nv_raddr;
    logic [15:0] nv_rdata;
    logic ms_tick;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            if (c[7] ^ w[i]) begin
                c = {c[6:0], 1'b0} ^ CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction

    function automatic logic [2:0] slot_addr(input logic [2:0] idx);
        case (idx)
            3'h0: slot_addr = NV_TEMP_OFFSET;
            3'h1: slot_addr = NV_ALTITUDE;
            3'h2: slot_addr = NV_AUTO_BASE;
            3'h3: slot_addr = NV_FORCED_HIST;
            default: slot_addr = NV_AUTO_HIST;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    smc_nvmem #(.AW(3), .DW(16)) u_store (
        .sys_clk(sys_clk),
        .we(nv_we),
        .waddr(nv_waddr),
        .wdata(nv_wdata),
        .raddr(nv_raddr),
        .rdata_r(nv_rdata)
    );

    always_comb begin
        r_nxt = r_r;
        r_nxt.cmd_nack = 1'b0;
        r_nxt.cmd_done = 1'b0;
        r_nxt.tx_valid = 1'b0;
        r_nxt.tx_nack = 1'b0;
        r_nxt.cfg_load = 1'b0;
        nv_we = 1'b0;
        nv_waddr = slot_addr(r_r.idx);
        nv_wdata = 16'h0000;
        nv_raddr = slot_addr(r_r.idx);
        ms_tick = (r_r.tick == 16'(CYC_PER_MS - 1));
        r_nxt.tick = ms_tick ? 16'h0000 : r_r.tick + 16'h0001;
        if (ms_tick && r_r.ms_left != 14'h0000) begin
            r_nxt.ms_left = r_r.ms_left - 14'h0001;
        end

        // Byte reads: a read with nothing ready, or while busy, is refused.
        if (rd_req) begin
            if (!r_r.busy && r_r.rsp_left != 4'h0) begin
                r_nxt.tx_data = r_r.rsp_buf[71:64];
                r_nxt.tx_valid = 1'b1;
                r_nxt.rsp_buf = {r_r.rsp_buf[63:0], 8'h00};
                r_nxt.rsp_left = r_r.rsp_left - 4'h1;
            end else begin
                r_nxt.tx_nack = 1'b1;
            end
        end

        case (r_r.state)
            SMC_IDLE: begin
                if (cmd_valid) begin
                    r_nxt.rsp_left = 4'h0;
                    r_nxt.tick = 16'h0000;
                    r_nxt.idx = 3'h0;
                    r_nxt.busy = 1'b1;
                    r_nxt.state = SMC_NVWR;
                    case (cmd_code)
                        CMD_SAVE_CFG: begin
                            r_nxt.op = OP_SAVE;
                            r_nxt.ms_left = 14'(SAVE_MS); // [R1]
                        end
                        CMD_FACTORY_RST: begin
                            r_nxt.op = OP_FACTORY;
                            r_nxt.ms_left = 14'(FACTORY_MS); // [R9]
                        end
                        CMD_SERIAL: begin
                            r_nxt.op = OP_SERIAL;
                            r_nxt.ms_left = 14'(SERIAL_MS); // [R5]
                            r_nxt.state = SMC_WAIT;
                        end
                        CMD_SELF_TEST: begin
                            r_nxt.op = OP_SELF_TEST;
                            r_nxt.ms_left = 14'(SELF_TEST_MS); // [R7]
                            r_nxt.state = SMC_WAIT;
                        end
                        default: begin
                            r_nxt.busy = 1'b0;
                            r_nxt.cmd_nack = 1'b1;
                            r_nxt.state = SMC_IDLE;
                        end
                    endcase
                end else if (r_r.hist_pend) begin
                    // History is committed only between commands.
                    r_nxt.idx = IDX_FIRST_HIST;
                    r_nxt.hist_pend = 1'b0;
                    r_nxt.state = SMC_HIST; // [R4]
                end
            end
            SMC_NVWR: begin
                nv_we = 1'b1;
                if (r_r.op == OP_FACTORY) begin
                    case (r_r.idx)
                        3'h0: nv_wdata = DEF_TEMP_OFFSET; // [R9]
                        3'h1: nv_wdata = DEF_ALTITUDE;
                        3'h2: nv_wdata = {15'h0000, DEF_AUTO_BASE};
                        default: nv_wdata = 16'h0000; // [R9]
                    endcase
                end else begin
                    case (r_r.idx)
                        3'h0: nv_wdata = cfg_temp_offset; // [R1] [R2]
                        3'h1: nv_wdata = cfg_altitude;
                        default: nv_wdata = {15'h0000,
                            cfg_auto_baseline_correction};
                    endcase
                end
                r_nxt.idx = r_r.idx + 3'h1;
                if (r_r.op == OP_SAVE && r_r.idx == IDX_LAST_CFG) begin
                    r_nxt.state = SMC_WAIT;
                end else if (r_r.idx == IDX_LAST) begin
                    r_nxt.idx = 3'h0;
                    r_nxt.state = SMC_NVRD;
                end
            end
            SMC_NVRD: begin
                // Read back the defaults so the live settings follow them.
                r_nxt.idx = r_r.idx + 3'h1;
                case (r_r.idx)
                    3'h1: r_nxt.ld_toff = nv_rdata;
                    3'h2: r_nxt.ld_alt = nv_rdata;
                    3'h3: begin
                        r_nxt.ld_abc = nv_rdata[0];
                        r_nxt.cfg_load = 1'b1; // [R9]
                        r_nxt.state = SMC_WAIT;
                    end
                    default: ;
                endcase
            end
            SMC_WAIT: begin
                if (r_r.ms_left == 14'h0000) begin
                    r_nxt.busy = 1'b0;
                    r_nxt.cmd_done = 1'b1;
                    r_nxt.state = SMC_IDLE;
                    if (r_r.op == OP_SERIAL) begin
                        r_nxt.rsp_buf = {SERIAL_NUM[47:32],
                            crc8(SERIAL_NUM[47:32]),
                            SERIAL_NUM[31:16], crc8(SERIAL_NUM[31:16]),
                            SERIAL_NUM[15:0], crc8(SERIAL_NUM[15:0])};
                        r_nxt.rsp_left = SERIAL_LEN; // [R5] [R10]
                    end else if (r_r.op == OP_SELF_TEST) begin
                        r_nxt.rsp_buf = {self_test_status,
                            crc8(self_test_status), 48'h0};
                        r_nxt.rsp_left = SELF_TEST_LEN; // [R7] [R8] [R10]
                    end
                end
            end
            SMC_HIST: begin
                nv_we = 1'b1;
                nv_wdata = (r_r.idx == IDX_FIRST_HIST) ?
                    hist_forced_recalibration :
                    hist_auto_baseline_correction; // [R4]
                r_nxt.idx = r_r.idx + 3'h1;
                if (r_r.idx == IDX_LAST) begin
                    r_nxt.state = SMC_IDLE;
                end
            end
            default: r_nxt.state = SMC_IDLE;
        endcase
        // A history change in the same cycle as the clear is kept.
        if (hist_update) begin
            r_nxt.hist_pend = 1'b1; // [R4]
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign busy = r_r.busy;
    assign cmd_nack = r_r.cmd_nack;
    assign cmd_done = r_r.cmd_done;
    assign tx_data = r_r.tx_data;
    assign tx_valid = r_r.tx_valid;
    assign tx_nack = r_r.tx_nack;
    assign cfg_load = r_r.cfg_load;
    assign load_temp_offset = r_r.ld_toff;
    assign load_altitude = r_r.ld_alt;
    assign load_auto_baseline_correction = r_r.ld_abc;
endmodule

// *** src/smc_nvmem.sv ***
// Small word store standing in for the non-volatile memory.
// Assumes one clock; contents survive the logic reset.
`timescale 1ns/10ps
module smc_nvmem #(
    parameter int AW = 3,
    parameter int DW = 16
) (
    input wire logic sys_clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata_r
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // No reset on the array: a logic reset must not wipe stored words.
    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_r <= mem[raddr];
    end
endmodule

// *** src/smc_pkg.sv ***
// Constants shared by the maintenance command interpreter and its store.
// Assumes a single 50 MHz system clock.
package smc_pkg;
    localparam int CLK_HZ = 50000000;
    localparam int MS_CYCLES = CLK_HZ / 1000;

    localparam logic [15:0] CMD_SAVE_CFG = 16'h3615;
    localparam logic [15:0] CMD_SERIAL = 16'h3682;
    localparam logic [15:0] CMD_SELF_TEST = 16'h3639;
    localparam logic [15:0] CMD_FACTORY_RST = 16'h3632;

    // Longest execution times in milliseconds.
    localparam int T_SAVE_MS = 800;
    localparam int T_SERIAL_MS = 1;
    localparam int T_SELF_TEST_MS = 10000;
    localparam int T_FACTORY_MS = 1200;

    // Response lengths in bytes.
    localparam logic [3:0] SERIAL_LEN = 4'h9;
    localparam logic [3:0] SELF_TEST_LEN = 4'h3;

    // Checksum parameters.
    localparam logic [7:0] CRC_POLY = 8'h31;
    localparam logic [7:0] CRC_INIT = 8'hff;

    // Non-volatile store word addresses.
    localparam logic [2:0] NV_TEMP_OFFSET = 3'h0;
    localparam logic [2:0] NV_ALTITUDE = 3'h1;
    localparam logic [2:0] NV_AUTO_BASE = 3'h2;
    localparam logic [2:0] NV_FORCED_HIST = 3'h4;
    localparam logic [2:0] NV_AUTO_HIST = 3'h5;

    // Slot indices walked by the write sequencer.
    localparam logic [2:0] IDX_FIRST_HIST = 3'h3;
    localparam logic [2:0] IDX_LAST_CFG = 3'h2;
    localparam logic [2:0] IDX_LAST = 3'h4;

    // Factory defaults of the configuration.
    localparam logic [15:0] DEF_TEMP_OFFSET = 16'h0000;
    localparam logic [15:0] DEF_ALTITUDE = 16'h0000;
    localparam logic DEF_AUTO_BASE = 1'b1;

    // Unique serial number; the value is arbitrary.
    localparam logic [47:0] SERIAL_DEFAULT = 48'h0123_4567_89ab;

    typedef enum logic [2:0] {
        SMC_IDLE = 3'b000,
        SMC_NVWR = 3'b001,
        SMC_NVRD = 3'b011,
        SMC_WAIT = 3'b010,
        SMC_HIST = 3'b110
    } smc_state_t;

    typedef enum logic [1:0] {
        OP_SAVE = 2'h0,
        OP_SERIAL = 2'h1,
        OP_SELF_TEST = 2'h2,
        OP_FACTORY = 2'h3
    } smc_op_t;
endpackage
